// file: core/wcas_pkg.sv
`default_nettype none
package wcas_pkg;
   // ======================================================================
   // Register map (byte addresses)
   localparam logic [7:0] WCAS_CTRL_OFS   = 8'h00;
   localparam logic [7:0] WCAS_TOUT_OFS   = 8'h04;
   localparam logic [7:0] WCAS_RFTOUT_OFS = 8'h08;
   localparam logic [7:0] WCAS_STAT_OFS   = 8'h0c;
   localparam logic [7:0] WCAS_MASK_OFS   = 8'h10;
   localparam logic [7:0] WCAS_CODE_OFS   = 8'h14;
   localparam logic [7:0] WCAS_LIVE_OFS   = 8'h18;
   // ======================================================================
   // Control bits
   localparam int CTRL_SDLY_EN = 0;
   localparam int CTRL_ILK_EN  = 1;
   localparam int CTRL_PART_EN = 2;
   localparam int CTRL_RFSW_EN = 3;
   localparam int CTRL_CLEAR   = 4;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] TOUT_RST    = 32'h0000_2710;
   localparam logic [31:0] RFTOUT_RST  = 32'h0000_03e8;
   // ======================================================================
   // Status bit positions, one per alarm
   localparam int ST_N = 28;
   localparam int ST_E701 = 0;
   localparam int ST_E702 = 1;
   localparam int ST_E703 = 2;
   localparam int ST_E704 = 3;
   localparam int ST_E705 = 4;
   localparam int ST_E706 = 5;
   localparam int ST_E707 = 6;
   localparam int ST_E801 = 7;
   localparam int ST_E802 = 8;
   localparam int ST_EA01 = 9;  // EA:01..EA:06 at 9..14
   localparam int ST_EB01 = 15; // Eb:01..Eb:06 at 15..20
   localparam int ST_EB11 = 21; // Eb:11..Eb:16 at 21..26
   localparam int ST_RSVD = 27;
   // ======================================================================
   // Alarm group codes
   localparam logic [3:0] GRP_NOCYC = 4'h7;
   localparam logic [3:0] GRP_COMM  = 4'h8;
   localparam logic [3:0] GRP_HW    = 4'ha;
   localparam logic [3:0] GRP_OVL   = 4'hb;
   localparam logic [4:0] HORN_COUNT = 5'h10;
   // ======================================================================
   // Alarm code carrier
   typedef struct packed {
      logic [3:0] group;
      logic [7:0] entry;
   } wcas_code_t;
   // Overload sensor inputs, one bit per quantity
   typedef struct packed {
      logic temp;
      logic volt;
      logic power;
      logic freq;
      logic current;
      logic phase;
   } wcas_ovl_t;
   typedef enum logic [3:0] {
      CY_IDLE  = 4'b0001,
      CY_ULS   = 4'b0010,
      CY_TRIG  = 4'b0100,
      CY_WELD  = 4'b1000
   } wcas_cyc_t;
endpackage
`default_nettype wire

// file: core/wcas_top.sv
// What this block does
// - Group 7 alarms raised in a cycle abort it; E7:04/E7:06/E7:07 refuse the start instead
// - E7:01 when upper limit stays active
// - E7:02 when trigger misses its time-out
// - E7:03 when sonics-delay input times out
// - E7:04 when interlock inactive at start
// - E7:05 when RF feedback misses time
// - E7:06 when part absent at start
// - E7:07 when horn number sixteen or more with RF requested
// - Link failures abort, report E8:01/E8:02
// - Link and hardware alarms hold while present
// - Hardware alarm blocks start, aborts cycle
// - Hardware codes EA:01 to EA:06
// - Idle overloads never abort or count
// - Seek overloads raise Eb:01 to Eb:05
// - Test overloads raise Eb:11 to Eb:15
// - Heat-sink Eb:06/Eb:16 hold while hot
`default_nettype none
module wcas_top
   import wcas_pkg::*;
(
   input  wire logic        CLOCK,       // 10 MHz clock
   input  wire logic        RSTN,        // Async reset, active low
   input  wire logic        PSEL,        // APB select
   input  wire logic        PENABLE,     // APB access phase
   input  wire logic        PWRITE,      // APB direction
   input  wire logic [7:0]  PADDR,       // APB byte address
   input  wire logic [31:0] PWDATA,      // APB write data
   output logic      [31:0] PRDATA,      // APB read data
   output logic             PREADY,      // APB ready
   output logic             PSLVERR,     // APB error
   input  wire logic        CYCLE_START, // Cycle start pin
   input  wire logic        UPPER_LIMIT_SWITCH, // Actuator up, active high
   input  wire logic        TRIGGER_SWITCH,     // Trigger, active high
   input  wire logic        SONICS_DELAY_IN,    // External sonics delay input
   input  wire logic        INTERLOCK_IN,       // User interlock
   input  wire logic        PART_PRESENT_IN,    // Part present
   input  wire logic        RF_SWITCH_REQ,      // RF switch requested
   input  wire logic        RF_SWITCH_FB,       // RF switch feedback
   input  wire logic [7:0]  HORN_NUMBER,        // Preset horn number
   input  wire logic        WELD_DONE,          // Weld finished normally
   input  wire logic [1:0]  LINK_FAIL,          // Serial, display link faults
   input  wire logic [5:0]  HW_FAULT,           // EA:01..EA:06 sources
   input  wire logic        SEEK_ACTIVE,        // Seek running
   input  wire logic        TEST_ACTIVE,        // Test running
   input  wire wcas_ovl_t   OVL_IN,             // Overload sensors
   output logic             CYCLE_ACTIVE,       // Weld cycle in progress
   output logic             CYCLE_ABORT,        // Abort pulse
   output logic             START_BLOCK,        // Starts refused
   output logic             WELD_COUNT_INC,     // Weld counter step
   output logic             GENERAL_ALARM,      // Any alarm latched
   output wcas_code_t       ALARM_CODE,         // Last raised code
   output logic             IRQ                 // Interrupt, active high
);
   // ======================================================================
   // Input synchronisers: all pins except HORN_NUMBER and the APB bus cross two flops
   localparam int NSYNC = 18;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   assign raw_in = {OVL_IN, HW_FAULT, LINK_FAIL, RF_SWITCH_FB, PART_PRESENT_IN,
                    INTERLOCK_IN, SONICS_DELAY_IN};
   logic [9:0] syncb1_reg;
   logic [9:0] syncb2_reg;
   // Both stages register only; nothing reads stage one but stage two
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         sync1_reg  <= '0;
         sync2_reg  <= '0;
         syncb1_reg <= '0;
         syncb2_reg <= '0;
      end
      else
      begin
         sync1_reg  <= raw_in;
         sync2_reg  <= sync1_reg;
         syncb1_reg <= {CYCLE_START, UPPER_LIMIT_SWITCH, TRIGGER_SWITCH, RF_SWITCH_REQ,
                        WELD_DONE, SEEK_ACTIVE, TEST_ACTIVE, 3'b000};
         syncb2_reg <= syncb1_reg;
      end
   end
   logic       s_sdly, s_ilk, s_part, s_rffb, s_start, s_uls, s_trig, s_rfreq, s_done;
   logic       s_seek, s_test;
   logic [1:0] s_link;
   logic [5:0] s_hw;
   logic [5:0] s_ovl;
   assign s_sdly  = sync2_reg[0];
   assign s_ilk   = sync2_reg[1];
   assign s_part  = sync2_reg[2];
   assign s_rffb  = sync2_reg[3];
   assign s_link  = sync2_reg[5:4];
   assign s_hw    = sync2_reg[11:6];
   assign s_ovl   = sync2_reg[17:12];
   assign s_start = syncb2_reg[9];
   assign s_uls   = syncb2_reg[8];
   assign s_trig  = syncb2_reg[7];
   assign s_rfreq = syncb2_reg[6];
   assign s_done  = syncb2_reg[5];
   assign s_seek  = syncb2_reg[4];
   assign s_test  = syncb2_reg[3];

   // ======================================================================
   // Registers
   logic [31:0]   ctrl_reg, ctrl_next;
   logic [31:0]   tout_reg, tout_next;
   logic [31:0]   rftout_reg, rftout_next;
   logic [ST_N-1:0] stat_reg, stat_next;
   logic [ST_N-1:0] mask_reg, mask_next;
   wcas_code_t    code_reg, code_next;
   logic [31:0]   prdata_reg, prdata_next;
   logic          wr_en, rd_en, addr_ok;
   logic [ST_N-1:0] evt;     // Alarm set pulses or levels
   logic [ST_N-1:0] persist; // Conditions still present
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign rd_en = PSEL && !PENABLE && !PWRITE; // Captured in setup phase
   assign addr_ok = (PADDR <= WCAS_LIVE_OFS) && (PADDR[1:0] == 2'b00);
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;
   assign PRDATA  = prdata_reg;

   // ======================================================================
   // Cycle sequencer with time-out counter
   wcas_cyc_t   cyc_reg, cyc_next;
   logic [31:0] tcnt_reg, tcnt_next;
   logic [31:0] rfcnt_reg, rfcnt_next;
   logic        rfwait_reg, rfwait_next;
   logic        start_d_reg, start_d_next;
   logic        abort_reg, abort_next;
   logic        cnt_reg, cnt_next;
   logic        start_edge, nocyc_hit, hw_any, link_any, abort_cond;
   logic        ovl_ok;
   assign start_edge = s_start && !start_d_reg;
   assign hw_any     = |s_hw;
   assign link_any   = |s_link;
   assign nocyc_hit  = |evt[ST_E707:ST_E701];
   assign abort_cond = (cyc_reg != CY_IDLE) && (nocyc_hit || link_any || hw_any);

   always_comb
   begin
      cyc_next     = cyc_reg;
      tcnt_next    = tcnt_reg;
      rfcnt_next   = rfcnt_reg;
      rfwait_next  = rfwait_reg;
      start_d_next = s_start;
      abort_next   = 1'b0;
      cnt_next     = 1'b0;
      evt          = '0;
      // time-out counts down, reloaded on each cycle event
      if (tcnt_reg != 32'h0)
         tcnt_next = tcnt_reg - 32'h1;
      case (cyc_reg)
         CY_IDLE:
         begin
            // starts refused while hardware alarm stands
            if (start_edge && !hw_any && !link_any)
            begin
               if (ctrl_reg[CTRL_ILK_EN] && !s_ilk)
                  evt[ST_E704] = 1'b1;
               if (ctrl_reg[CTRL_PART_EN] && !s_part)
                  evt[ST_E706] = 1'b1;
               if (s_rfreq && ({1'b0, HORN_NUMBER} >= {4'h0, HORN_COUNT}))
                  evt[ST_E707] = 1'b1;
               if (evt[ST_E707:ST_E701] == 7'h0)
               begin
                  cyc_next  = CY_ULS;
                  tcnt_next = tout_reg;
               end
            end
         end
         CY_ULS:
         begin
            if (!s_uls)
            begin
               cyc_next  = CY_TRIG;
               tcnt_next = tout_reg;
            end
            else if (tcnt_reg == 32'h0)
               evt[ST_E701] = 1'b1;
         end
         CY_TRIG:
         begin
            if (s_trig)
            begin
               cyc_next  = CY_WELD;
               tcnt_next = tout_reg;
            end
            else if (tcnt_reg == 32'h0)
               evt[ST_E702] = 1'b1;
         end
         CY_WELD:
         begin
            if (ctrl_reg[CTRL_SDLY_EN] && !s_sdly && tcnt_reg == 32'h0)
               evt[ST_E703] = 1'b1;
            if (s_done)
            begin
               cyc_next = CY_IDLE;
               cnt_next = 1'b1;
            end
         end
         default: cyc_next = CY_IDLE;
      endcase
      if (!rfwait_reg && s_rfreq && ctrl_reg[CTRL_RFSW_EN])
      begin
         rfwait_next = 1'b1;
         rfcnt_next  = rftout_reg;
      end
      else if (rfwait_reg)
      begin
         if (s_rffb || !s_rfreq)
            rfwait_next = 1'b0;
         else if (rfcnt_reg == 32'h0)
         begin
            evt[ST_E705] = 1'b1;
            rfwait_next  = 1'b0;
         end
         else
            rfcnt_next = rfcnt_reg - 32'h1;
      end
      evt[ST_E802:ST_E801] = s_link;
      evt[ST_EA01+5:ST_EA01] = s_hw;
      // overloads only when no weld cycle runs
      ovl_ok = (cyc_reg == CY_IDLE);
      evt[ST_EB01+5:ST_EB01] = (ovl_ok && s_seek) ? s_ovl : 6'h0;
      evt[ST_EB11+5:ST_EB11] = (ovl_ok && s_test) ? s_ovl : 6'h0;
      if (abort_cond)
      begin
         cyc_next   = CY_IDLE;
         abort_next = 1'b1;
         cnt_next   = 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cyc_reg     <= CY_IDLE;
         tcnt_reg    <= 32'h0;
         rfcnt_reg   <= 32'h0;
         rfwait_reg  <= 1'b0;
         start_d_reg <= 1'b0;
         abort_reg   <= 1'b0;
         cnt_reg     <= 1'b0;
      end
      else
      begin
         cyc_reg     <= cyc_next;
         tcnt_reg    <= tcnt_next;
         rfcnt_reg   <= rfcnt_next;
         rfwait_reg  <= rfwait_next;
         start_d_reg <= start_d_next;
         abort_reg   <= abort_next;
         cnt_reg     <= cnt_next;
      end
   end

   // ======================================================================
   // Register file, sticky status; set beats clear
   // Held alarms cannot be cleared while their cause remains
   assign persist = {1'b0, 6'h0, 6'h0, s_hw, s_link, 7'h0};
   logic [ST_N-1:0] hold;
   always_comb
   begin
      ctrl_next   = ctrl_reg;
      tout_next   = tout_reg;
      rftout_next = rftout_reg;
      mask_next   = mask_reg;
      code_next   = code_reg;
      prdata_next = 32'h0;
      hold        = persist;
      // temperature alarms hold while still hot
      hold[ST_EB01+5] = stat_reg[ST_EB01+5] & s_ovl[5];
      hold[ST_EB11+5] = stat_reg[ST_EB11+5] & s_ovl[5];
      stat_next   = stat_reg;
      if (wr_en && PADDR == WCAS_STAT_OFS)
         stat_next = stat_reg & ~PWDATA[ST_N-1:0];
      if (wr_en && PADDR == WCAS_CTRL_OFS && PWDATA[CTRL_CLEAR])
         stat_next = '0;
      stat_next = stat_next | evt | (hold & stat_reg);
      if (wr_en)
      begin
         case (PADDR)
            WCAS_CTRL_OFS:   ctrl_next   = {28'h0, PWDATA[3:0]};
            WCAS_TOUT_OFS:   tout_next   = PWDATA;
            WCAS_RFTOUT_OFS: rftout_next = PWDATA;
            WCAS_MASK_OFS:   mask_next   = PWDATA[ST_N-1:0];
            default:         ctrl_next   = ctrl_reg;
         endcase
      end
      // latch group and entry of newest alarm
      for (int i = 0; i < ST_N; i++)
      begin
         if (evt[i] && !stat_reg[i])
         begin
            if (i <= ST_E707)
               code_next = '{GRP_NOCYC, 8'(i + 1)};
            else if (i <= ST_E802)
               code_next = '{GRP_COMM, 8'(i - ST_E801 + 1)};
            else if (i < ST_EB01)
               code_next = '{GRP_HW, 8'(i - ST_EA01 + 1)};
            else if (i < ST_EB11)
               code_next = '{GRP_OVL, 8'(i - ST_EB01 + 1)};
            else
               code_next = '{GRP_OVL, 8'(i - ST_EB11 + 17)};
         end
      end
      if (stat_next == '0)
         code_next = '{4'h0, 8'h00};
      if (rd_en)
      begin
         case (PADDR)
            WCAS_CTRL_OFS:   prdata_next = ctrl_reg;
            WCAS_TOUT_OFS:   prdata_next = tout_reg;
            WCAS_RFTOUT_OFS: prdata_next = rftout_reg;
            WCAS_STAT_OFS:   prdata_next = {4'h0, stat_reg};
            WCAS_MASK_OFS:   prdata_next = {4'h0, mask_reg};
            WCAS_CODE_OFS:   prdata_next = {20'h0, code_reg};
            WCAS_LIVE_OFS:   prdata_next = {28'h0, cyc_reg};
            default:         prdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ctrl_reg   <= CTRL_RST;
         tout_reg   <= TOUT_RST;
         rftout_reg <= RFTOUT_RST;
         stat_reg   <= '0;
         mask_reg   <= '0;
         code_reg   <= '{4'h0, 8'h00};
         prdata_reg <= 32'h0;
      end
      else
      begin
         ctrl_reg   <= ctrl_next;
         tout_reg   <= tout_next;
         rftout_reg <= rftout_next;
         stat_reg   <= stat_next;
         mask_reg   <= mask_next;
         code_reg   <= code_next;
         prdata_reg <= prdata_next;
      end
   end

   // ======================================================================
   // Outputs
   assign CYCLE_ACTIVE   = (cyc_reg != CY_IDLE);
   assign CYCLE_ABORT    = abort_reg;
   assign WELD_COUNT_INC = cnt_reg;
   assign START_BLOCK    = hw_any || link_any;
   // general alarm while any status bit stands
   assign GENERAL_ALARM  = |stat_reg;
   assign ALARM_CODE     = code_reg;
   assign IRQ            = |(stat_reg & mask_reg);

   // ======================================================================
   // Checks
   property p_nocyc_abort;
      @(posedge CLOCK) disable iff (!RSTN)
      (cyc_reg != CY_IDLE && nocyc_hit) |=> CYCLE_ABORT && !CYCLE_ACTIVE;
   endproperty
   a_nocyc_abort: assert property (p_nocyc_abort) else $error("no-cycle alarm did not abort");
   property p_uls_tout;
      @(posedge CLOCK) disable iff (!RSTN)
      (cyc_reg == CY_ULS && s_uls && tcnt_reg == 32'h0) |=> stat_reg[ST_E701];
   endproperty
   a_uls_tout: assert property (p_uls_tout) else $error("E7:01 missing");
   property p_trig_tout;
      @(posedge CLOCK) disable iff (!RSTN)
      (cyc_reg == CY_TRIG && !s_trig && tcnt_reg == 32'h0) |=> stat_reg[ST_E702] ##1 !CYCLE_ACTIVE;
   endproperty
   a_trig_tout: assert property (p_trig_tout) else $error("E7:02 missing");
   property p_ilk;
      @(posedge CLOCK) disable iff (!RSTN)
      (cyc_reg == CY_IDLE && start_edge && !START_BLOCK && ctrl_reg[CTRL_ILK_EN] && !s_ilk)
         |=> stat_reg[ST_E704] && !CYCLE_ACTIVE;
   endproperty
   a_ilk: assert property (p_ilk) else $error("E7:04 missing");
   property p_link_hold;
      @(posedge CLOCK) disable iff (!RSTN)
      s_link[0] |=> stat_reg[ST_E801];
   endproperty
   a_link_hold: assert property (p_link_hold) else $error("E8:01 not held");
   property p_hw_block;
      @(posedge CLOCK) disable iff (!RSTN)
      (hw_any && cyc_reg == CY_IDLE) |=> !CYCLE_ACTIVE;
   endproperty
   a_hw_block: assert property (p_hw_block) else $error("cycle started under hardware alarm");
   property p_ovl_idle;
      @(posedge CLOCK) disable iff (!RSTN)
      (cyc_reg == CY_IDLE && !nocyc_hit && !hw_any && !link_any) |=> !CYCLE_ABORT && !WELD_COUNT_INC;
   endproperty
   a_ovl_idle: assert property (p_ovl_idle) else $error("idle overload disturbed cycle");
   property p_gen;
      @(posedge CLOCK) disable iff (!RSTN)
      $rose(GENERAL_ALARM) |-> ALARM_CODE.group != 4'h0;
   endproperty
   a_gen: assert property (p_gen) else $error("general alarm without code");
endmodule // wcas_top
`default_nettype wire

// file: bench/wcas_actuator.sv
`default_nettype none
// ======================================================================
// Actuator head and trigger switch model
module wcas_actuator
(
   input  wire logic       clock,        // Bench clock
   input  wire logic       rstn,         // Async reset, active low
   input  wire logic       cycle_active, // Device cycle running
   input  wire logic [1:0] mode,         // 0 normal, 1 head stuck up, 2 no part
   output logic            upper_limit_switch,          // Upper limit, high while head is up
   output logic            trig          // Trigger, high on part contact
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] step_reg;
   // Steps through the stroke only while the device runs a cycle
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         step_reg <= 4'h0;
      else if (!cycle_active)
         step_reg <= 4'h0;
      else if (step_reg != 4'hf)
         step_reg <= step_reg + 4'h1;
   end
   // Head returns up at once on abort, so no trigger can linger after it
   assign upper_limit_switch  = !(cycle_active && step_reg >= 4'h3 && mode != 2'h1);
   assign trig = cycle_active && step_reg >= 4'h8 && mode == 2'h0;
endmodule // wcas_actuator
`default_nettype wire

// file: bench/weld_cycle_alarm_supervisor_test.sv
`default_nettype none
// ======================================================================
// Self-checking bench
module weld_cycle_alarm_supervisor_test;
   timeunit 1ns;
   timeprecision 1ns;
   import wcas_pkg::*;
   localparam int TOUT = 40;
   localparam int LIMIT = 30000;
   localparam logic [31:0] ALL = 32'h0fff_ffff;
   logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
   logic [7:0]  paddr = 8'h00, horn = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic        start = 1'b0, sdly_in = 1'b0, ilk_in = 1'b1, part_in = 1'b1, rf_req = 1'b0, rf_fb = 1'b0;
   logic        weld_done = 1'b0, seek = 1'b0, test = 1'b0, upper_limit_switch, trig;
   logic        cyc_act, cyc_abort, start_block, wc_inc, gen_alarm, irq;
   logic [1:0]  link_fail = 2'h0, mode = 2'h0;
   logic [5:0]  hw_fault = 6'h0;
   wcas_ovl_t   ovl = '0;
   wcas_code_t  code;
   int          n_fail = 0, compares = 0, n_abort = 0, n_inc = 0, cycles = 0;

   wcas_top dut_u (.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CYCLE_START(start), .UPPER_LIMIT_SWITCH(upper_limit_switch), .TRIGGER_SWITCH(trig), .SONICS_DELAY_IN(sdly_in),
      .INTERLOCK_IN(ilk_in), .PART_PRESENT_IN(part_in), .RF_SWITCH_REQ(rf_req), .RF_SWITCH_FB(rf_fb),
      .HORN_NUMBER(horn), .WELD_DONE(weld_done), .LINK_FAIL(link_fail), .HW_FAULT(hw_fault),
      .SEEK_ACTIVE(seek), .TEST_ACTIVE(test), .OVL_IN(ovl), .CYCLE_ACTIVE(cyc_act), .CYCLE_ABORT(cyc_abort),
      .START_BLOCK(start_block), .WELD_COUNT_INC(wc_inc), .GENERAL_ALARM(gen_alarm), .ALARM_CODE(code),
      .IRQ(irq));
   wcas_actuator act_u (.clock(clock), .rstn(rstn), .cycle_active(cyc_act), .mode(mode), .upper_limit_switch(upper_limit_switch), .trig(trig));

   // ======================================================================
   // Clock, pulse counters and hang guard
   always #50 clock = ~clock;
   always @(posedge clock)
   begin
      n_abort <= n_abort + ((cyc_abort === 1'b1) ? 1 : 0);
      n_inc <= n_inc + ((wc_inc === 1'b1) ? 1 : 0);
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         n_fail++;
         final_report();
      end
   end

   // ======================================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // One transfer, then one idle edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask
   task automatic pulse_start();
      start <= 1'b1;
      repeat (4) @(posedge clock);
      start <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wait_cyc(input logic lvl, input int lim, output int n);
      n = 0;
      while (cyc_act !== lvl && n < lim)
      begin
         @(posedge clock);
         n++;
      end
      check({31'h0, cyc_act}, {31'h0, lvl});
   endtask
   task automatic clear_all();
      wr(WCAS_STAT_OFS, ALL);
      rd_chk(WCAS_STAT_OFS, 32'h0);
      check({20'h0, code}, 32'h0);
      check({30'h0, gen_alarm, irq}, 32'h0);
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_regs();
      rd_chk(WCAS_CTRL_OFS, CTRL_RST);
      rd_chk(WCAS_TOUT_OFS, TOUT_RST);
      rd_chk(WCAS_RFTOUT_OFS, RFTOUT_RST);
      rd_chk(WCAS_LIVE_OFS, 32'h1);
      apb(1'b0, 8'h1c, 32'h0);
      check({31'h0, rerr}, 32'h1);
      check(rdata, 32'h0);
      wr(WCAS_TOUT_OFS, TOUT);
      rd_chk(WCAS_TOUT_OFS, TOUT);
      wr(WCAS_MASK_OFS, ALL);
      wr(WCAS_RFTOUT_OFS, 32'h8);
      wr(WCAS_CTRL_OFS, 32'h8);
      rf_req <= 1'b1;
      repeat (16) @(posedge clock);
      rf_fb <= 1'b1;
      rd_chk(WCAS_STAT_OFS, 32'h1 << ST_E705);
      clear_all();
      {rf_req, rf_fb} <= 2'b00;
   endtask
   // Whole cycle; negative bitn means a clean weld
   task automatic t_cycle(input logic [1:0] m, input logic sdly, input int bitn);
      int a0, i0, n;
      a0 = n_abort;
      i0 = n_inc;
      mode <= m;
      wr(WCAS_CTRL_OFS, {31'h0, sdly});
      pulse_start();
      wait_cyc(1'b1, 20, n);
      if (bitn < 0)
      begin
         repeat (12) @(posedge clock);
         weld_done <= 1'b1;
         @(posedge clock);
         weld_done <= 1'b0;
      end
      wait_cyc(1'b0, 3 * TOUT, n);
      @(posedge clock);
      if (bitn >= 0)
         check({31'h0, n >= TOUT - 8}, 32'h1);
      check(32'(n_abort - a0), {31'h0, bitn >= 0});
      check(32'(n_inc - i0), {31'h0, bitn < 0});
      rd_chk(WCAS_STAT_OFS, (bitn < 0) ? 32'h0 : (32'h1 << bitn));
      check({20'h0, code}, (bitn < 0) ? 32'h0 : {20'h0, GRP_NOCYC, 8'(bitn + 1)});
      check({31'h0, gen_alarm}, {31'h0, bitn >= 0});
      mode <= 2'h0;
      clear_all();
   endtask
   // Start refused; pins are interlock, part, RF request
   task automatic t_refuse(input logic [31:0] ctl, input logic [2:0] pins, input logic [7:0] hn, input int bitn);
      logic seen;
      wr(WCAS_CTRL_OFS, ctl);
      {ilk_in, part_in, rf_req} <= pins;
      horn <= hn;
      repeat (3) @(posedge clock);
      pulse_start();
      seen = 1'b0;
      repeat (8)
      begin
         @(posedge clock);
         seen = seen | (cyc_act !== 1'b0);
      end
      check({31'h0, seen}, 32'h0);
      rd_chk(WCAS_STAT_OFS, 32'h1 << bitn);
      check({20'h0, code}, {20'h0, GRP_NOCYC, 8'(bitn + 1)});
      check({30'h0, gen_alarm, irq}, 32'h3);
      {ilk_in, part_in, rf_req} <= 3'b110;
      horn <= 8'h00;
      clear_all();
   endtask
   task automatic t_hw();
      for (int i = 0; i < 6; i++)
      begin
         hw_fault <= 6'(1 << i);
         repeat (4) @(posedge clock);
         check({31'h0, start_block}, 32'h1);
         pulse_start();
         repeat (6) @(posedge clock);
         check({31'h0, cyc_act}, 32'h0);
         wr(WCAS_STAT_OFS, ALL);
         rd_chk(WCAS_STAT_OFS, 32'h1 << (ST_EA01 + i));
         check({20'h0, code}, {20'h0, GRP_HW, 8'(i + 1)});
         check({31'h0, irq}, 32'h1);
         wr(WCAS_MASK_OFS, 32'h0);
         check({31'h0, irq}, 32'h0);
         wr(WCAS_MASK_OFS, ALL);
         hw_fault <= 6'h0;
         repeat (4) @(posedge clock);
         clear_all();
      end
   endtask
   // Link loss with the head held up aborts at once
   task automatic t_link();
      int a0, n;
      for (int i = 0; i < 2; i++)
      begin
         a0 = n_abort;
         mode <= 2'h1;
         pulse_start();
         wait_cyc(1'b1, 20, n);
         repeat (5) @(posedge clock);
         link_fail <= 2'(1 << i);
         wait_cyc(1'b0, 20, n);
         @(posedge clock);
         check(32'(n_abort - a0), 32'h1);
         check({31'h0, start_block}, 32'h1);
         wr(WCAS_STAT_OFS, ALL);
         rd_chk(WCAS_STAT_OFS, 32'h1 << (ST_E801 + i));
         check({20'h0, code}, {20'h0, GRP_COMM, 8'(i + 1)});
         link_fail <= 2'h0;
         mode <= 2'h0;
         repeat (4) @(posedge clock);
         clear_all();
      end
   endtask
   // Each overload in turn; temperature holds while hot
   task automatic t_ovl(input logic s, input logic t, input int base, input logic [7:0] ent);
      int a0, i0;
      for (int i = 0; i < 6; i++)
      begin
         a0 = n_abort;
         i0 = n_inc;
         seek <= s;
         test <= t;
         ovl <= wcas_ovl_t'(6'(1 << i));
         repeat (4) @(posedge clock);
         if (i < 5)
            ovl <= '0;
         seek <= 1'b0;
         test <= 1'b0;
         repeat (3) @(posedge clock);
         rd_chk(WCAS_STAT_OFS, 32'h1 << (base + i));
         check({20'h0, code}, {20'h0, GRP_OVL, ent + 8'(i)});
         wr(WCAS_STAT_OFS, ALL);
         rd_chk(WCAS_STAT_OFS, (i == 5) ? (32'h1 << (base + i)) : 32'h0);
         check(32'(n_abort - a0 + n_inc - i0), 32'h0);
         ovl <= '0;
         repeat (4) @(posedge clock);
         clear_all();
      end
   endtask

   // ======================================================================
   // Main sequence
   initial
   begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_regs();
      t_cycle(2'h0, 1'b0, -1);
      t_cycle(2'h1, 1'b0, ST_E701);
      t_cycle(2'h2, 1'b0, ST_E702);
      t_cycle(2'h0, 1'b1, ST_E703);
      sdly_in <= 1'b1;
      t_cycle(2'h0, 1'b1, -1);
      sdly_in <= 1'b0;
      t_refuse(32'h2, 3'b010, 8'h00, ST_E704);
      t_refuse(32'h4, 3'b100, 8'h00, ST_E706);
      t_refuse(32'h0, 3'b111, 8'h10, ST_E707);
      t_refuse(32'h2, 3'b011, 8'h0f, ST_E704);
      t_hw();
      t_link();
      t_ovl(1'b1, 1'b0, ST_EB01, 8'h01);
      t_ovl(1'b0, 1'b1, ST_EB11, 8'h11);
      final_report();
   end
endmodule // weld_cycle_alarm_supervisor_test
`default_nettype wire
